// File: verilog/apss_pkg.sv
// Constants for the per-axis pause and synchronous start block
// Assumes a 32-bit classic Wishbone slave port and four axes
// Operation
// - Command written while paused waits for release
// - Each axis set and clear driven independently
// - One host command pauses or releases axis groups
// - Configuration maps pause onto sensor, selects axes
// - Active sensor pauses selected axes, flag set
// - Per-axis release event selectable, counter included
// - Default set condition is the assigned sensor
// - Group release frees all named axes together
// - Released axes clear flags and start together
// - Fast stop then release discards held command
// - Host clear, release event, sensor drop end pause
// - Hardware reset clears pause and held commands
// - Same set and release event means release
// - Counter events are per-axis counter interrupts
package apss_pkg;
  localparam int          APSS_AXES        = 4;
  localparam int          APSS_COND_W      = 4;
  localparam int          APSS_ADR_W       = 8;
  localparam int          APSS_DAT_W       = 32;
  // Register byte addresses
  localparam logic [7:0]  ADR_PAUSE_CMD    = 8'h00;
  localparam logic [7:0]  ADR_INPUT_ASSIGN = 8'h04;
  localparam logic [7:0]  ADR_ASSERT_COND  = 8'h08;
  localparam logic [7:0]  ADR_RELEASE_COND = 8'h0c;
  localparam logic [7:0]  ADR_PULSE_CMD    = 8'h10;
  localparam logic [7:0]  ADR_STATUS       = 8'h14;
  // Field positions
  localparam int          SET_MASK_LSB     = 0;
  localparam int          CLR_MASK_LSB     = 4;
  localparam int          ASSIGN_EN_BIT    = 0;
  localparam int          ASSIGN_AXES_LSB  = 4;
  localparam int          PULSE_WR_LSB     = 0;
  localparam int          FAST_STOP_LSB    = 4;
  localparam int          ST_PAUSE_LSB     = 0;
  localparam int          ST_STANDBY_FLAG_LSB      = 4;
  localparam int          ST_HELD_LSB      = 8;
  localparam int          ST_SENSOR_BIT    = 12;
  // Condition codes: 0 default, 1..4 counter event of axis 0..3
  localparam logic [3:0]  COND_DEFAULT     = 4'h0;
  localparam logic [3:0]  COND_CNT_FIRST   = 4'h1;
  localparam logic [3:0]  COND_CNT_LAST    = 4'h4;
  // Reset values
  localparam logic [15:0] COND_RST         = 16'h0000;
  localparam logic [3:0]  AXES_RST         = 4'h0;
  localparam logic [31:0] DAT_ZERO         = 32'h0000_0000;
endpackage : apss_pkg

// File: verilog/apss_sync.sv
// Two-stage synchroniser for one asynchronous pin
// Assumes the pin is a slow level with no glitch filtering needed
`timescale 1ns/10ps
`default_nettype none
module apss_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic stage1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : apss_sync
`default_nettype wire

// File: verilog/apss_axis.sv
// Pause state and held pulse-output command for one axis
// Assumes set, clear and command strobes are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module apss_axis (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set_evt,
  input  wire logic clr_evt,
  input  wire logic cmd_write,
  input  wire logic fast_stop,
  output logic      pause,
  output logic      held,
  output logic      abort,
  output logic      standby,
  output logic      start
);
  logic next_pause;
  logic next_held;

  always_comb begin
    next_pause = pause;
    if (clr_evt) begin
      next_pause = 1'b0;
    end else if (set_evt) begin
      next_pause = 1'b1;
    end
    next_held = held;
    if (cmd_write) begin
      next_held = 1'b1;
    end else if (held && !pause) begin
      next_held = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pause   <= 1'b0;
      held    <= 1'b0;
      standby <= 1'b0;
    end else begin
      pause   <= next_pause;
      held    <= next_held;
      standby <= next_pause & next_held;
    end
  end

  // Fast stop marks the held command to be dropped at release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abort <= 1'b0;
    end else if (fast_stop && (held || cmd_write)) begin
      abort <= 1'b1;
    end else if (cmd_write || (held && !pause)) begin
      abort <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start <= 1'b0;
    end else begin
      start <= held & ~pause & ~abort & ~fast_stop;
    end
  end
endmodule : apss_axis
`default_nettype wire

// File: verilog/apss_top.sv
// Per-axis pause gating with synchronous start, Wishbone slave
// Assumes a classic Wishbone master on MCLK, an asynchronous sensor
// pin and counter interrupt events from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module apss_top
  import apss_pkg::*;
(
  input  wire logic                  MCLK,
  input  wire logic                  RST_N,
  input  wire logic                  CYC_I,
  input  wire logic                  STB_I,
  input  wire logic                  WE_I,
  input  wire logic [APSS_ADR_W-1:0] ADR_I,
  input  wire logic [APSS_DAT_W-1:0] DAT_I,
  input  wire logic [3:0]            SEL_I,
  output logic                       ACK_O,
  output logic      [APSS_DAT_W-1:0] DAT_O,
  input  wire logic                  EXTERNAL_SENSOR_INPUT_ZERO,
  input  wire logic [APSS_AXES-1:0]  COUNTER_INTERRUPT_EVENT,
  output logic      [APSS_AXES-1:0]  PULSE_START,
  output logic      [APSS_AXES-1:0]  PAUSE_FLAG,
  output logic      [APSS_AXES-1:0]  STANDBY_FLAG
);

  // Bus request decode
  logic                 wb_req;
  logic                 wb_wr;
  logic                 wb_rd;
  logic                 lane0;
  logic                 lane1;

  // Software-written configuration
  logic                 assign_en;
  logic [APSS_AXES-1:0] assign_axes;
  logic [15:0]          assert_cond;
  logic [15:0]          release_cond;

  // One-cycle command strobes
  logic [APSS_AXES-1:0] cmd_set;
  logic [APSS_AXES-1:0] cmd_clr;
  logic [APSS_AXES-1:0] pulse_wr;
  logic [APSS_AXES-1:0] fast_stop;

  // Sensor pin and its edges
  logic                 sens_lvl;
  logic                 sens_prev;
  logic                 sens_rise;
  logic                 sens_fall;

  // Per-axis state
  logic [APSS_AXES-1:0] set_evt;
  logic [APSS_AXES-1:0] clr_evt;
  logic [APSS_AXES-1:0] pause;
  logic [APSS_AXES-1:0] held;
  logic [APSS_AXES-1:0] abort;
  logic [APSS_AXES-1:0] standby;
  logic [APSS_AXES-1:0] start;

  // True when a condition code names a counter event that is active
  function automatic logic cnt_hit(input logic [3:0]           cond,
                                   input logic [APSS_AXES-1:0] ev);
    logic [3:0] idx;
    idx = cond - COND_CNT_FIRST;
    cnt_hit = 1'b0;
    if (cond >= COND_CNT_FIRST && cond <= COND_CNT_LAST) begin
      cnt_hit = ev[idx[1:0]];
    end
  endfunction : cnt_hit

  // Writes land at the edge where the master sees the acknowledge
  assign wb_req = CYC_I & STB_I & ~ACK_O;
  assign wb_wr  = CYC_I & STB_I & ACK_O & WE_I;
  assign wb_rd  = wb_req & ~WE_I;
  assign lane0  = SEL_I[0];
  assign lane1  = SEL_I[1];

  // Single-cycle acknowledge, dropped in the cycle after it is given
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= wb_req;
    end
  end

  // Configuration registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      assign_en   <= 1'b0;
      assign_axes <= AXES_RST;
    end else if (wb_wr && lane0 && ADR_I == ADR_INPUT_ASSIGN) begin
      assign_en   <= DAT_I[ASSIGN_EN_BIT];
      assign_axes <= DAT_I[ASSIGN_AXES_LSB +: APSS_AXES];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      assert_cond <= COND_RST;
    end else if (wb_wr && ADR_I == ADR_ASSERT_COND) begin
      if (lane0) begin
        assert_cond[7:0] <= DAT_I[7:0];
      end
      if (lane1) begin
        assert_cond[15:8] <= DAT_I[15:8];
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      release_cond <= COND_RST;
    end else if (wb_wr && ADR_I == ADR_RELEASE_COND) begin
      if (lane0) begin
        release_cond[7:0] <= DAT_I[7:0];
      end
      if (lane1) begin
        release_cond[15:8] <= DAT_I[15:8];
      end
    end
  end

  // Command strobes last the one cycle in which the write is taken
  always_comb begin
    cmd_set   = '0;
    cmd_clr   = '0;
    pulse_wr  = '0;
    fast_stop = '0;
    if (wb_wr && lane0 && ADR_I == ADR_PAUSE_CMD) begin
      cmd_set = DAT_I[SET_MASK_LSB +: APSS_AXES];
      cmd_clr = DAT_I[CLR_MASK_LSB +: APSS_AXES];
    end
    if (wb_wr && lane0 && ADR_I == ADR_PULSE_CMD) begin
      pulse_wr  = DAT_I[PULSE_WR_LSB +: APSS_AXES];
      fast_stop = DAT_I[FAST_STOP_LSB +: APSS_AXES];
    end
  end

  // Read data, zero for unmapped addresses
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      DAT_O <= DAT_ZERO;
    end else if (wb_rd) begin
      DAT_O <= DAT_ZERO;
      case (ADR_I)
        ADR_INPUT_ASSIGN: begin
          DAT_O[ASSIGN_EN_BIT]                    <= assign_en;
          DAT_O[ASSIGN_AXES_LSB +: APSS_AXES]     <= assign_axes;
        end
        ADR_ASSERT_COND: begin
          DAT_O[15:0] <= assert_cond;
        end
        ADR_RELEASE_COND: begin
          DAT_O[15:0] <= release_cond;
        end
        ADR_STATUS: begin
          DAT_O[ST_PAUSE_LSB +: APSS_AXES] <= pause;
          DAT_O[ST_STANDBY_FLAG_LSB +: APSS_AXES]  <= standby;
          DAT_O[ST_HELD_LSB +: APSS_AXES]  <= held;
          DAT_O[ST_SENSOR_BIT]             <= sens_lvl;
        end
        default: begin
          DAT_O <= DAT_ZERO;
        end
      endcase
    end
  end

  // Sensor pin crossing and edge detection
  apss_sync u_sens (
    .clk   (MCLK),
    .rst_n (RST_N),
    .din   (EXTERNAL_SENSOR_INPUT_ZERO),
    .dout  (sens_lvl)
  );

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sens_prev <= 1'b0;
    end else begin
      sens_prev <= sens_lvl;
    end
  end

  assign sens_rise = sens_lvl & ~sens_prev;
  assign sens_fall = ~sens_lvl & sens_prev;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  genvar i;
  generate
    for (i = 0; i < APSS_AXES; i++) begin : g_axis
      logic [3:0] acond;
      logic [3:0] rcond;
      logic       ext_sel;
      logic       cnt_set;
      logic       cnt_clr;

      assign acond   = assert_cond[APSS_COND_W*i +: APSS_COND_W];
      assign rcond   = release_cond[APSS_COND_W*i +: APSS_COND_W];
      assign ext_sel = assign_en & assign_axes[i];
      assign cnt_set = cnt_hit(acond, COUNTER_INTERRUPT_EVENT);
      assign cnt_clr = cnt_hit(rcond, COUNTER_INTERRUPT_EVENT);

      // Set and clear sources are combined per axis
      assign set_evt[i] = cmd_set[i]
        | (ext_sel & (acond == COND_DEFAULT) & sens_rise)
        | cnt_set;
      assign clr_evt[i] = cmd_clr[i]
        | (ext_sel & sens_fall)
        | cnt_clr;

      apss_axis u_axis (
        .clk       (MCLK),
        .rst_n     (RST_N),
        .set_evt   (set_evt[i]),
        .clr_evt   (clr_evt[i]),
        .cmd_write (pulse_wr[i]),
        .fast_stop (fast_stop[i]),
        .pause     (pause[i]),
        .held      (held[i]),
        .abort     (abort[i]),
        .standby   (standby[i]),
        .start     (start[i])
      );

      pause_hold_a: assert property (
        pause[i] && !clr_evt[i] |=> pause[i])
        else $error("pause dropped without release event");

      release_wins_a: assert property (
        clr_evt[i] |=> !pause[i])
        else $error("release event did not clear pause");

      sensor_set_a: assert property (
        sens_rise && ext_sel && acond == COND_DEFAULT && !clr_evt[i]
        |=> PAUSE_FLAG[i])
        else $error("sensor did not pause selected axis");

      flag_mirror_a: assert property (
        !set_evt[i] && !clr_evt[i] |=> $stable(PAUSE_FLAG[i]))
        else $error("pause flag changed without event");

      paused_no_start_a: assert property (
        held[i] && pause[i] |=> !PULSE_START[i])
        else $error("pulse started while paused");

      standby_match_a: assert property (
        STANDBY_FLAG[i] == (pause[i] && held[i]))
        else $error("standby flag disagrees with held pause");

      release_start_a: assert property (
        held[i] && pause[i] && clr_evt[i] && !abort[i]
        && !fast_stop[i] && !pulse_wr[i]
        |=> !PAUSE_FLAG[i] ##1 PULSE_START[i])
        else $error("released axis did not start");

      discard_held_a: assert property (
        held[i] && pause[i] && fast_stop[i] && !pulse_wr[i]
        |=> (!PULSE_START[i])[*3])
        else $error("discarded command produced a start");

      host_set_a: assert property (
        cmd_set[i] && !clr_evt[i] |=> PAUSE_FLAG[i])
        else $error("host set did not pause axis");

      sensor_release_a: assert property (
        ext_sel && sens_fall |=> !PAUSE_FLAG[i])
        else $error("sensor drop did not release axis");

      counter_set_a: assert property (
        cnt_set && !clr_evt[i] |=> PAUSE_FLAG[i])
        else $error("counter event did not pause axis");

      counter_release_a: assert property (
        cnt_clr |=> !PAUSE_FLAG[i])
        else $error("counter event did not release axis");

      free_start_a: assert property (
        pulse_wr[i] && !fast_stop[i] && !pause[i] && !set_evt[i]
        |=> ##1 PULSE_START[i])
        else $error("unpaused command did not start");

      abort_drop_a: assert property (
        held[i] && abort[i] && !pause[i] && !pulse_wr[i]
        |=> !held[i] && !PULSE_START[i] ##1 !PULSE_START[i])
        else $error("aborted command was not dropped");
    end
  endgenerate

  assign PAUSE_FLAG   = pause;
  assign STANDBY_FLAG = standby;
  assign PULSE_START  = start;

  group_release_a: assert property (
    |cmd_clr |=> (PAUSE_FLAG & $past(cmd_clr)) == '0)
    else $error("group release left an axis paused");

  group_start_a: assert property (
    (cmd_clr & held & pause & ~abort) != '0 && !(|pulse_wr)
    && !(|fast_stop)
    |=> ##1 (PULSE_START & $past(cmd_clr & held & pause & ~abort, 2))
        == $past(cmd_clr & held & pause & ~abort, 2))
    else $error("group release did not start together");

  all_pause_a: assert property (
    cmd_set == '1 && clr_evt == '0 |=> PAUSE_FLAG == '1)
    else $error("pause-all command missed an axis");

  ack_single_a: assert property (
    ACK_O |=> !ACK_O)
    else $error("acknowledge held longer than one cycle");

  // Bus-side checks
  ack_answer_a: assert property (
    CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not acknowledged in one cycle");

  assign_write_a: assert property (
    wb_wr && lane0 && ADR_I == ADR_INPUT_ASSIGN
    |=> assign_en == $past(DAT_I[ASSIGN_EN_BIT])
        && assign_axes == $past(DAT_I[ASSIGN_AXES_LSB +: APSS_AXES]))
    else $error("input assignment not stored");

  cond_write_a: assert property (
    wb_wr && lane0 && ADR_I == ADR_RELEASE_COND
    |=> release_cond[APSS_COND_W-1:0]
        == $past(DAT_I[APSS_COND_W-1:0]))
    else $error("release condition not stored");

  status_read_a: assert property (
    wb_rd && ADR_I == ADR_STATUS
    |=> DAT_O[ST_STANDBY_FLAG_LSB +: APSS_AXES] == $past(standby)
        && DAT_O[ST_PAUSE_LSB +: APSS_AXES] == $past(pause))
    else $error("status read disagrees with axis state");

  sensor_cover_c: cover property (sens_rise && assign_en ##1 |pause);
  group_cover_c: cover property (
    $countones(standby) >= 2 && $countones(cmd_clr & standby) >= 2);
  counter_cover_c: cover property (
    |(clr_evt & ~cmd_clr & held & pause) ##2 |PULSE_START);
  discard_cover_c: cover property (|(fast_stop & held & pause));
  start_cover_c: cover property (|pulse_wr && pause == '0 ##2 |PULSE_START);

endmodule : apss_top
`default_nettype wire

// File: tb/apss_host_model.sv
// Host processor model: classic Wishbone master, one request at a time
// Assumes a slave on the same clock that acks every request
`timescale 1ns/10ps
`default_nettype none
module apss_host_model
  import apss_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  req,
  input  wire logic                  req_we,
  input  wire logic [APSS_ADR_W-1:0] req_adr,
  input  wire logic [APSS_DAT_W-1:0] req_dat,
  output logic                       done,
  output logic      [APSS_DAT_W-1:0] rdat,
  output logic                       cyc,
  output logic                       stb,
  output logic                       we,
  output logic      [APSS_ADR_W-1:0] adr,
  output logic      [APSS_DAT_W-1:0] wdat,
  output logic      [3:0]            sel,
  input  wire logic                  ack,
  input  wire logic [APSS_DAT_W-1:0] dat_in
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc  <= 1'b0;
      stb  <= 1'b0;
      we   <= 1'b0;
      adr  <= '0;
      wdat <= DAT_ZERO;
      sel  <= 4'h0;
      done <= 1'b0;
      rdat <= DAT_ZERO;
    end else if (cyc && ack) begin
      // Released address and data lines show inverted values; we and sel keep their old values
      cyc  <= 1'b0;
      stb  <= 1'b0;
      adr  <= ~adr;
      wdat <= ~wdat;
      rdat <= dat_in;
      done <= 1'b1;
    end else if (!cyc && req && !done) begin
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= req_we;
      adr  <= req_adr;
      wdat <= req_dat;
      sel  <= 4'hf;
    end else begin
      done <= 1'b0;
    end
  end
endmodule : apss_host_model
`default_nettype wire

// File: tb/tb_axis_pause_sync_start.sv
// Self-checking bench for the pause and synchronous start block
// Assumes the host model as bus master and the bench as sensor source
`timescale 1ns/10ps
`default_nettype none
module tb_axis_pause_sync_start
  import apss_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sensor = 1'b0;
  logic [3:0]  cnt_ev = 4'h0;
  logic        req = 1'b0;
  logic        req_we = 1'b0;
  logic [7:0]  req_adr = 8'h00;
  logic [31:0] req_dat = 32'h0;
  logic        done;
  logic [31:0] rdat;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [3:0]  sel;
  logic        ack;
  logic [31:0] dat_o;
  logic [3:0]  pulse_start;
  logic [3:0]  pause_flag;
  logic [3:0]  standby_flag;
  int          fails = 0;
  int          n_checks = 0;
  int          st_n[4] = '{0, 0, 0, 0};
  int          st_cyc = 0;
  int          b_n[4];
  int          b_cyc;

  always #10 mclk = ~mclk;

  apss_host_model u_host (.clk(mclk), .rst_n(rst_n), .req(req),
    .req_we(req_we), .req_adr(req_adr), .req_dat(req_dat), .done(done),
    .rdat(rdat), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .wdat(wdat),
    .sel(sel), .ack(ack), .dat_in(dat_o));

  apss_top u_dut (.MCLK(mclk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .DAT_I(wdat), .SEL_I(sel), .ACK_O(ack),
    .DAT_O(dat_o), .EXTERNAL_SENSOR_INPUT_ZERO(sensor),
    .COUNTER_INTERRUPT_EVENT(cnt_ev), .PULSE_START(pulse_start),
    .PAUSE_FLAG(pause_flag), .STANDBY_FLAG(standby_flag));

  // Counts start pulses per axis and cycles with any start
  always @(posedge mclk) begin
    if (pulse_start !== 4'h0) begin
      st_cyc++;
      for (int i = 0; i < 4; i++) begin
        st_n[i] += int'(pulse_start[i] === 1'b1);
      end
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge mclk);
    req     <= 1'b1;
    req_we  <= w;
    req_adr <= a;
    req_dat <= d;
    @(posedge mclk);
    req <= 1'b0;
    do begin
      @(negedge mclk);
    end while (done !== 1'b1);
  endtask : xfer

  task automatic rd(input string what, input logic [7:0] a,
                    input logic [31:0] exp);
    xfer(1'b0, a, DAT_ZERO);
    chk(what, exp, rdat);
  endtask : rd

  task automatic wait_clk(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_clk

  task automatic snap();
    b_n = st_n;
    b_cyc = st_cyc;
  endtask : snap

  // Starts since snap: {start cycles, axis 3..0 counts}
  task automatic chk_starts(input logic [31:0] exp);
    logic [31:0] v;
    v = {16'(st_cyc - b_cyc), 4'(st_n[3] - b_n[3]), 4'(st_n[2] - b_n[2]),
         4'(st_n[1] - b_n[1]), 4'(st_n[0] - b_n[0])};
    chk("starts", exp, v);
  endtask : chk_starts

  task automatic cnt_pulse(input logic [3:0] m);
    @(posedge mclk);
    cnt_ev <= m;
    @(posedge mclk);
    cnt_ev <= 4'h0;
    wait_clk(3);
  endtask : cnt_pulse

  task automatic note(input string name);
    $display("End of test %s: checks %0d fails %0d", name, n_checks, fails);
  endtask : note

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    test_done();
  end

  initial begin
    repeat (3) @(negedge mclk);
    chk("pause in reset", 32'h0, {28'h0, pause_flag});
    @(posedge mclk);
    rst_n <= 1'b1;
    rd("assert cond", ADR_ASSERT_COND, 32'h0);
    rd("release cond", ADR_RELEASE_COND, 32'h0);
    rd("assign", ADR_INPUT_ASSIGN, 32'h0);
    xfer(1'b1, 8'h3c, 32'hffff_ffff);
    rd("unmapped", 8'h3c, 32'h0);
    rd("pause cmd", ADR_PAUSE_CMD, 32'h0);
    note("registers");
    snap();
    xfer(1'b1, ADR_PULSE_CMD, 32'h2);
    wait_clk(3);
    chk_starts(32'h0001_0010);
    note("free start");
    snap();
    xfer(1'b1, ADR_PAUSE_CMD, 32'h0f);
    chk("pause all", 32'h0f, {28'h0, pause_flag});
    xfer(1'b1, ADR_PULSE_CMD, 32'h05);
    chk("standby", 32'h05, {28'h0, standby_flag});
    wait_clk(5);
    chk_starts(32'h0);
    rd("status", ADR_STATUS, 32'h0000_055f);
    xfer(1'b1, ADR_PAUSE_CMD, 32'h50);
    chk("partial release", 32'h0a, {28'h0, pause_flag});
    wait_clk(3);
    chk_starts(32'h0001_0101);
    note("group release");
    snap();
    xfer(1'b1, ADR_PULSE_CMD, 32'h0a);
    chk("standby held", 32'h0a, {28'h0, standby_flag});
    xfer(1'b1, ADR_PULSE_CMD, 32'ha0);
    xfer(1'b1, ADR_PAUSE_CMD, 32'ha0);
    wait_clk(3);
    chk_starts(32'h0);
    rd("status abort", ADR_STATUS, 32'h0);
    note("abort");
    xfer(1'b1, ADR_INPUT_ASSIGN, 32'h51);
    rd("assign back", ADR_INPUT_ASSIGN, 32'h51);
    @(posedge mclk);
    sensor <= 1'b1;
    wait_clk(6);
    chk("sensor pause", 32'h05, {28'h0, pause_flag});
    xfer(1'b1, ADR_PULSE_CMD, 32'h01);
    chk("sensor standby", 32'h01, {28'h0, standby_flag});
    snap();
    @(posedge mclk);
    sensor <= 1'b0;
    wait_clk(6);
    chk("sensor drop", 32'h0, {28'h0, pause_flag});
    chk_starts(32'h0001_0001);
    xfer(1'b1, ADR_INPUT_ASSIGN, 32'h0);
    note("sensor");
    xfer(1'b1, ADR_ASSERT_COND, 32'h10);
    cnt_pulse(4'h1);
    chk("counter set", 32'h02, {28'h0, pause_flag});
    cnt_pulse(4'h8);
    chk("still paused", 32'h02, {28'h0, pause_flag});
    xfer(1'b1, ADR_RELEASE_COND, 32'h40);
    cnt_pulse(4'h8);
    chk("counter clear", 32'h0, {28'h0, pause_flag});
    xfer(1'b1, ADR_RELEASE_COND, 32'h10);
    cnt_pulse(4'h1);
    chk("same event", 32'h0, {28'h0, pause_flag});
    note("counter");
    xfer(1'b1, ADR_PAUSE_CMD, 32'h0f);
    xfer(1'b1, ADR_PULSE_CMD, 32'h0f);
    snap();
    @(posedge mclk);
    rst_n <= 1'b0;
    wait_clk(2);
    chk("reset pause", 32'h0, {28'h0, pause_flag});
    chk("reset standby", 32'h0, {28'h0, standby_flag});
    @(posedge mclk);
    rst_n <= 1'b1;
    wait_clk(5);
    chk_starts(32'h0);
    rd("status reset", ADR_STATUS, 32'h0);
    note("reset");
    test_done();
  end
endmodule : tb_axis_pause_sync_start
`default_nettype wire
